// ---- rct_timer.sv ----
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module rct_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // pins
  input  wire logic        external_trigger_pin,
  input  wire logic        count_input_pin,
  input  wire logic        ext_osc_clk,
  output logic             toggle_out,
  output logic             toggle_out_en,
  // system strobes
  output logic             irq_request,
  output logic             wrap_strobe
);
  // all module state
  typedef struct packed {
    rct_pkg::rct_ctl_t ctl;
    rct_pkg::rct_cfg_t cfg;
    logic [15:0]       count;
    logic [15:0]       reload;
    logic              aw_got;
    logic [7:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              wrap;
  } rct_state_t;

  rct_state_t st;
  rct_state_t next_st;

  rct_pkg::rct_pins_t pin_sync;  // synchronised levels
  rct_pkg::rct_pins_t pin_fall;  // one-cycle falling edges
  logic       div2_pulse;        // sys / 2
  logic       div12_pulse;       // sys / 12
  logic       ext8_pulse;        // ext osc / 8
  logic       timer_tick;        // selected timer clock
  logic       count_event;       // one count step
  logic       count_down;        // direction
  logic       trig_fall_ok;      // trigger edge usable
  logic       wr_fire;           // write takes effect
  logic       rd_fire;           // read accepted
  logic [7:0] wr_byte;           // low byte of write data
  logic [7:0] rd_byte;           // selected read byte
  logic       rd_hit;            // read address mapped
  logic       wr_hit;            // write address mapped

  rct_sync u_sync_trig (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (external_trigger_pin),
    .sync    (pin_sync.trig),
    .fall    (pin_fall.trig)
  );

  rct_sync u_sync_cnt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (count_input_pin),
    .sync    (pin_sync.cnt),
    .fall    (pin_fall.cnt)
  );

  rct_sync u_sync_osc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (ext_osc_clk),
    .sync    (pin_sync.ext_clk),
    .fall    (pin_fall.ext_clk)
  );

  // prescaled enables; ext osc counted on its falls
  rct_prescale u_div2 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (1'b1),
    .divisor (rct_pkg::DIV_2),
    .pulse   (div2_pulse)
  );

  rct_prescale u_div12 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (1'b1),
    .divisor (rct_pkg::DIV_12),
    .pulse   (div12_pulse)
  );

  rct_prescale u_ext8 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (pin_fall.ext_clk),
    .divisor (rct_pkg::DIV_8),
    .pulse   (ext8_pulse)
  );

  always_comb begin
    unique case (st.cfg.clk_sel)
      rct_pkg::CLK_DIV12: timer_tick = div12_pulse;
      rct_pkg::CLK_SYS:   timer_tick = 1'b1;
      rct_pkg::CLK_EXT8:  timer_tick = ext8_pulse;
      rct_pkg::CLK_DIV2:  timer_tick = div2_pulse;
    endcase
  end

  // timer clock or count pin falls
  assign count_event = st.ctl.run &&
                       (st.ctl.cnt_sel ? pin_fall.cnt : timer_tick);
  // direction from trigger level when down enabled
  assign count_down = st.cfg.down_en && !pin_sync.trig;
  // edge counts only with enable and no down mode
  assign trig_fall_ok = pin_fall.trig && st.ctl.ext_en &&
                        !st.cfg.down_en;

  // bus decode helpers
  assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
  assign rd_fire = s_axi_arvalid && !st.rvalid;
  assign wr_byte = st.w_data[7:0];
  assign wr_hit  = (st.aw_addr <= rct_pkg::ADDR_COUNT_HI) &&
                   (st.aw_addr[1:0] == 2'b00);
  assign rd_hit  = (s_axi_araddr <= rct_pkg::ADDR_COUNT_HI) &&
                   (s_axi_araddr[1:0] == 2'b00);

  // read mux; reserved bits read zero
  always_comb begin
    unique case (s_axi_araddr)
      rct_pkg::ADDR_CONTROL:   rd_byte = st.ctl & rct_pkg::CTL_MASK;
      rct_pkg::ADDR_CONFIG:    rd_byte = st.cfg & rct_pkg::CFG_MASK;
      rct_pkg::ADDR_RELOAD_LO: rd_byte = st.reload[7:0];
      rct_pkg::ADDR_RELOAD_HI: rd_byte = st.reload[15:8];
      rct_pkg::ADDR_COUNT_LO:  rd_byte = st.count[7:0];
      rct_pkg::ADDR_COUNT_HI:  rd_byte = st.count[15:8];
      default:                 rd_byte = rct_pkg::RST_BYTE;
    endcase
  end

  // next state: bus, then counter events (hardware wins)
  always_comb begin
    next_st      = st;
    next_st.wrap = 1'b0;

    // address and data taken in either order
    if (s_axi_awvalid && !st.aw_got) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_got) begin
      next_st.w_got  = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end

    // register write once both halves are here
    if (wr_fire) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_hit ? rct_pkg::RESP_OKAY
                              : rct_pkg::RESP_SLVERR;
      if (st.w_strb[0]) begin
        unique case (st.aw_addr)
          rct_pkg::ADDR_CONTROL:
            next_st.ctl = wr_byte & rct_pkg::CTL_MASK;
          // writing toggle state forces the output
          rct_pkg::ADDR_CONFIG:
            next_st.cfg = wr_byte & rct_pkg::CFG_MASK;
          rct_pkg::ADDR_RELOAD_LO: next_st.reload[7:0]  = wr_byte;
          rct_pkg::ADDR_RELOAD_HI: next_st.reload[15:8] = wr_byte;
          rct_pkg::ADDR_COUNT_LO:  next_st.count[7:0]   = wr_byte;
          rct_pkg::ADDR_COUNT_HI:  next_st.count[15:8]  = wr_byte;
          default: ;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // read answer one cycle after address
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, rd_byte};
      next_st.rresp  = rd_hit ? rct_pkg::RESP_OKAY
                              : rct_pkg::RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // counting; count events need run, trigger falls capture or reload even while stopped
    if (st.ctl.cap_sel) begin
      if (trig_fall_ok) begin
        next_st.reload       = st.count;
        next_st.ctl.ext_flag = 1'b1;
      end
      if (count_event) begin
        if (count_down) begin
          next_st.count = st.count - 16'h0001;
          if (st.count == rct_pkg::CNT_ZERO) begin
            next_st.ctl.ovf_flag = 1'b1;
            next_st.wrap         = 1'b1;
          end
        end else begin
          next_st.count = st.count + 16'h0001;
          if (st.count == rct_pkg::CNT_FULL) begin
            next_st.ctl.ovf_flag = 1'b1;
            next_st.wrap         = 1'b1;
          end
        end
      end
    end else begin
      if (count_event) begin
        if (count_down) begin
          // match on reload value, load FFFF
          if (st.count == st.reload) begin
            next_st.count        = rct_pkg::CNT_FULL;
            next_st.ctl.ovf_flag = 1'b1;
            next_st.wrap         = 1'b1;
          end else begin
            next_st.count = st.count - 16'h0001;
          end
        end else begin
          if (st.count == rct_pkg::CNT_FULL) begin
            next_st.count        = st.reload;
            next_st.ctl.ovf_flag = 1'b1;
            next_st.wrap         = 1'b1;
          end else begin
            next_st.count = st.count + 16'h0001;
          end
        end
      end
      // trigger fall reloads too, sets external flag
      if (trig_fall_ok) begin
        next_st.count        = st.reload;
        next_st.ctl.ext_flag = 1'b1;
      end
      // external flag acts as 17th bit on wraps
      if (next_st.wrap) begin
        next_st.ctl.ext_flag = ~st.ctl.ext_flag;
      end
    end

    // toggle output flips on every wrap while tog_oe is set
    if (next_st.wrap && st.cfg.tog_oe) begin
      next_st.cfg.tog_state = ~next_st.cfg.tog_state;
    end
  end

  // flags only change through writes or events above
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // handshake outputs
  assign s_axi_awready = !st.aw_got;
  assign s_axi_wready  = !st.w_got;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // toggle state bit is the pin level
  assign toggle_out    = st.cfg.tog_state;
  assign toggle_out_en = st.cfg.tog_oe;
  // request is level; the interrupt controller masks it
  assign irq_request   = st.ctl.ovf_flag |
                         (st.ctl.ext_flag & st.ctl.cap_sel) |
                         (st.ctl.ext_flag & st.ctl.ext_en &
                          !st.cfg.down_en);
  // wrap strobe for converter and uart scheduling
  assign wrap_strobe   = st.wrap;
endmodule
`default_nettype wire

// ---- rct_pkg.sv ----
package rct_pkg;

  // register byte addresses on the axi4-lite slave
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG    = 8'h04;
  localparam logic [7:0] ADDR_RELOAD_LO = 8'h08;
  localparam logic [7:0] ADDR_RELOAD_HI = 8'h0C;
  localparam logic [7:0] ADDR_COUNT_LO  = 8'h10;
  localparam logic [7:0] ADDR_COUNT_HI  = 8'h14;

  // control register bit positions
  localparam int CTL_CAP_SEL = 0;
  localparam int CTL_CNT_SEL = 1;
  localparam int CTL_RUN     = 2;
  localparam int CTL_EXT_EN  = 3;
  localparam int CTL_EXT_FLG = 6;
  localparam int CTL_OVF_FLG = 7;

  // configuration register bit positions
  localparam int CFG_DOWN_EN = 0;
  localparam int CFG_TOG_OE  = 1;
  localparam int CFG_TOG_ST  = 2;
  localparam int CFG_CLK_LO  = 3;
  localparam int CFG_CLK_HI  = 4;

  // writable masks; reserved bits read zero
  localparam logic [7:0] CTL_MASK = 8'hCF;
  localparam logic [7:0] CFG_MASK = 8'h1F;

  // reset byte and counter end values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_FULL  = 16'hFFFF;

  // clock select codes
  localparam logic [1:0] CLK_DIV12 = 2'b00;
  localparam logic [1:0] CLK_SYS   = 2'b01;
  localparam logic [1:0] CLK_EXT8  = 2'b10;
  localparam logic [1:0] CLK_DIV2  = 2'b11;

  // prescale divisors
  localparam logic [3:0] DIV_2  = 4'h2;
  localparam logic [3:0] DIV_8  = 4'h8;
  localparam logic [3:0] DIV_12 = 4'hC;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // control register fields
  typedef struct packed {
    logic       ovf_flag;
    logic       ext_flag;
    logic [1:0] rsvd;
    logic       ext_en;
    logic       run;
    logic       cnt_sel;
    logic       cap_sel;
  } rct_ctl_t;

  // configuration register fields
  typedef struct packed {
    logic [2:0] rsvd;
    logic [1:0] clk_sel;
    logic       tog_state;
    logic       tog_oe;
    logic       down_en;
  } rct_cfg_t;

  // synchronised pin samples
  typedef struct packed {
    logic trig;
    logic cnt;
    logic ext_clk;
  } rct_pins_t;

endpackage

// ---- rct_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser, one per pin, plus a delayed copy for edges
module rct_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic din,
  output logic      sync,
  output logic      fall
);
  // state: first stage, second stage, previous sample
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rct_sync_t;

  rct_sync_t st;
  rct_sync_t next_st;

  // shift chain; only s2 feeds s3, s1 is read by s2 alone
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  // idle-high reset avoids a false fall after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= 3'b111;
    end else begin
      st <= next_st;
    end
  end

  assign sync = st.s2;
  // falling edge from successive samples
  assign fall = st.s3 & ~st.s2;
endmodule
`default_nettype wire

// ---- rct_prescale.sv ----
`timescale 1ns/100ps
`default_nettype none
// divide-by-n enable pulse generator from a tick input
module rct_prescale (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick,
  input  wire logic [3:0] divisor,
  output logic            pulse
);
  typedef struct packed {
    logic [3:0] cnt;
  } rct_pre_t;

  rct_pre_t st;
  rct_pre_t next_st;

  // count ticks, wrap at divisor minus one
  always_comb begin
    next_st = st;
    if (tick) begin
      if (st.cnt == divisor - 4'h1) begin
        next_st.cnt = 4'h0;
      end else begin
        next_st.cnt = st.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = tick && (st.cnt == divisor - 4'h1);
endmodule
`default_nettype wire

// ---- rct_timer_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
// port-level relations of one timer
module rct_timer_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic toggle_out,
  input wire logic toggle_out_en,
  input wire logic irq_request,
  input wire logic wrap_strobe
);
  default clocking dclk @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // response two cycles after both halves land
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  // no second address while data still pending
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read data repeated");
  // pin moves only on a wrap or a register write
  a_toggle_cause: assert property (
    $changed(toggle_out) |-> wrap_strobe || s_axi_bvalid)
    else $error("toggle moved without cause");
  a_toggle_wrap: assert property (
    wrap_strobe && toggle_out_en && !s_axi_bvalid |-> $changed(toggle_out))
    else $error("toggle missed a wrap");
  a_wrap_flags: assert property (
    wrap_strobe |-> ##[0:1] irq_request) else $error("wrap left no flag");
  // flags only drop through software
  a_irq_sticky: assert property (
    $fell(irq_request) |-> s_axi_bvalid) else $error("flag fell alone");
  a_oe_by_write: assert property (
    $changed(toggle_out_en) |-> s_axi_bvalid) else $error("enable moved");
endmodule
bind rct_timer rct_timer_asserts rct_timer_asserts_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .toggle_out, .toggle_out_en,
  .irq_request, .wrap_strobe
);
`default_nettype wire

// ---- rct_pins_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// pin side: trigger level, count pin falls, free oscillator
module rct_pins_model (
  input  wire logic aclk,
  input  wire logic trig_lvl,
  input  wire logic fall_go,
  output logic      trig_pin,
  output logic      cnt_pin,
  output logic      osc_pin
);
  logic [1:0] osc_div = 2'b00; // oscillator phase, four cycles
  logic       cnt_q   = 1'b1;  // count pin idles high
  // moved on the far edge, never near the sampling edge
  always @(negedge aclk) begin
    osc_div <= osc_div + 2'b01;
    cnt_q   <= !fall_go;
  end
  assign cnt_pin  = cnt_q;
  assign trig_pin = trig_lvl;
  assign osc_pin  = osc_div[1];
endmodule
`default_nettype wire

// ---- tb_reload_capture_timer16.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_reload_capture_timer16;
  localparam logic [7:0] A_CT = rct_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_CF = rct_pkg::ADDR_CONFIG;
  localparam logic [7:0] A_RL = rct_pkg::ADDR_RELOAD_LO;
  localparam logic [7:0] A_RH = rct_pkg::ADDR_RELOAD_HI;
  localparam logic [7:0] A_CL = rct_pkg::ADDR_COUNT_LO;
  localparam logic [7:0] A_CH = rct_pkg::ADDR_COUNT_HI;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        arvalid = 1'b0;
  logic        trig    = 1'b1; // wanted trigger level
  logic        go      = 1'b0; // count pin fall request
  logic        awready, wready, bvalid, arready, rvalid;
  logic        trig_pin, cnt_pin, osc_pin;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        tog, tog_en, irq, wrap; // pin side and strobe outputs
  int          wraps = 0;      // wrap strobes seen
  int          wseen = 0;      // wraps at the previous pin check
  logic [41:0] exp_q[$];       // tolerance, resp, data
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;        // cycles for the timeout
  int          t0, t1, n;
  logic [15:0] v, rv;
  int          divs[4] = '{12, 1, 32, 2}; // by clock select code
  rct_timer rct_timer_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .external_trigger_pin(trig_pin), .count_input_pin(cnt_pin),
    .ext_osc_clk(osc_pin), .toggle_out(tog), .toggle_out_en(tog_en),
    .irq_request(irq), .wrap_strobe(wrap)
  );
  rct_pins_model rct_pins_model_i (
    .aclk(aclk), .trig_lvl(trig), .fall_go(go),
    .trig_pin(trig_pin), .cnt_pin(cnt_pin), .osc_pin(osc_pin)
  );
  always #5 aclk = !aclk;
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // oldest note against the answer; data may run up to tolerance
  task automatic chk_bus(input logic [1:0] r, input logic [31:0] d);
    logic [41:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
    tests_run++;
    if ($isunknown({r, d}) || r !== e[33:32] || d - e[31:0] > e[41:34]) begin
      $display("[FAIL] bus answer exp %h got %h", e[33:0], {r, d});
      err_total++;
    end
  endtask
  // pin levels and wraps since the previous pin check
  task automatic chk_pins(input logic [2:0] e, input int w);
    tests_run++;
    if ({tog, tog_en, irq} !== e || wraps - wseen != w) begin
      $display("[FAIL] pins exp %b wraps %0d got %b wraps %0d", e, w,
               {tog, tog_en, irq}, wraps - wseen);
      err_total++;
    end
    wseen = wraps;
  endtask
  // monitor plus hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (aresetn && wrap) wraps <= wraps + 1;
    if (aresetn && bvalid) chk_bus(bresp, 32'h0);
    if (aresetn && rvalid) chk_bus(rresp, rdata);
    if (cyc == 30000) begin
      err_total++;
      finish_test();
    end
  end
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    return (a > A_CH) ? rct_pkg::RESP_SLVERR : rct_pkg::RESP_OKAY;
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge aclk);
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s = 4'hF);
    exp_q.push_back({8'h00, resp_of(a), 32'h0});
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [7:0] t = 8'h00);
    exp_q.push_back({t, resp_of(a), e});
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, {24'h0, e[7:0]});
    rd(a + 8'h04, {24'h0, e[15:8]});
  endtask
  task automatic falls(input int c);
    repeat (c) begin
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      tick(4);
    end
    tick(4);
  endtask
  task automatic tfall;
    trig <= 1'b0;
    tick(6);
    trig <= 1'b1;
    tick(6);
  endtask
  initial begin
    n = $urandom(32'hCFEDE469);
    tick(12);
    aresetn <= 1'b1;
    for (int i = 0; i <= 24; i += 4) rd(8'(i), 32'h0);
    wr(8'h18, 8'h5A);
    v = 16'($urandom);
    wr(A_CL, v[7:0]);
    wr(A_CH, v[15:8]);
    wr(A_CT, 8'h30);
    wr(A_CL, ~v[7:0], 4'hE);
    tick(20);
    rd(A_CT, 32'h0);
    rd16(A_CL, v);
    n = 1 + $urandom % 8;
    wr(A_CT, 8'h06);
    falls(n);
    wr(A_CT, 8'h00);
    rd16(A_CL, v + 16'(n));
    chk_pins(3'b000, int'({1'b0, v} + 17'(n) > 17'h0FFFF));
    foreach (divs[i]) begin
      wr(A_CL, 8'h00);
      wr(A_CH, 8'h00);
      wr(A_CF, {3'b000, 2'(i), 3'b000});
      t0 = cyc;
      wr(A_CT, 8'h04);
      tick(240);
      t1 = cyc;
      wr(A_CT, 8'h00);
      rd(A_CL, 32'((t1 - t0) / divs[i] - 1), 8'h02);
    end
    wr(A_CF, 8'h00);
    v = 16'($urandom);
    wr(A_CL, v[7:0]);
    wr(A_CH, v[15:8]);
    wr(A_CT, 8'h07);
    tfall();
    rd(A_RL, 32'h0);
    wr(A_CT, 8'h0F);
    tfall();
    rd16(A_RL, v);
    rd(A_CT, 32'h4F);
    tick(30);
    rd(A_CT, 32'h4F);
    wr(A_CT, 8'h0F);
    wr(A_CF, 8'h01);
    wr(A_CL, ~v[7:0]);
    tfall();
    rd(A_RL, {24'h0, v[7:0]});
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    falls(1);
    rd16(A_CL, 16'h0000);
    rd(A_CT, 32'h8F);
    chk_pins(3'b001, 1);
    wr(A_CT, 8'h0F);
    trig <= 1'b0;
    tick(4);
    falls(1);
    rd16(A_CL, 16'hFFFF);
    rd(A_CT, 32'h8F);
    trig <= 1'b1;
    rv = 16'($urandom);
    wr(A_CF, 8'h02);
    wr(A_RL, rv[7:0]);
    wr(A_RH, rv[15:8]);
    wr(A_CL, 8'hFF);
    wr(A_CH, 8'hFF);
    wr(A_CT, 8'h06);
    falls(1);
    rd16(A_CL, rv);
    rd(A_CT, 32'hC6);
    rd(A_CF, 32'h06);
    chk_pins(3'b111, 2);
    wr(A_CT, 8'h0E);
    wr(A_CH, ~rv[15:8]);
    tfall();
    rd16(A_CL, rv);
    rd(A_CT, 32'h4E);
    chk_pins(3'b111, 0);
    wr(A_CF, 8'h03);
    trig <= 1'b0;
    tick(4);
    wr(A_CT, 8'h06);
    falls(1);
    rd16(A_CL, 16'hFFFF);
    rd(A_CT, 32'hC6);
    rd(A_CF, 32'h07);
    wr(A_CF, 8'h02);
    rd(A_CF, 32'h02);
    chk_pins(3'b011, 1);
    finish_test();
  end
endmodule
`default_nettype wire
